// *** hw/dsm_pkg.sv ***
package dsm_pkg;

   ////////////////////////////////////////////////////////////////////////////////////
   // Register byte addresses on the AXI4-Lite bus
   localparam int         ADDR_W    = 8;
   localparam logic [7:0] CTL_ADDR  = 8'h00;
   localparam logic [7:0] SRC_ADDR  = 8'h04;
   localparam logic [7:0] CARH_ADDR = 8'h08;
   localparam logic [7:0] CARL_ADDR = 8'h0C;

   ////////////////////////////////////////////////////////////////////////////////////
   // modulator_control fields
   localparam int         CTL_EN    = 7;
   localparam int         CTL_OE    = 6;
   localparam int         CTL_SLR   = 5;
   localparam int         CTL_OPOL  = 4;
   localparam int         CTL_OUT   = 3;
   localparam int         CTL_BIT   = 0;
   localparam logic [7:0] CTL_RST   = 8'h20;
   localparam logic [7:0] CTL_WMASK = 8'hF1;

   // high_carrier_control and low_carrier_control fields
   localparam int         CAR_DIS   = 7;
   localparam int         CAR_POL   = 6;
   localparam int         CAR_SYNC  = 5;
   localparam logic [7:0] CAR_RST   = 8'h00;
   localparam logic [7:0] CAR_WMASK = 8'hEF;

   // modulation_source_select fields
   localparam int         SRC_DIS   = 7;
   localparam logic [7:0] SRC_RST   = 8'h00;
   localparam logic [7:0] SRC_WMASK = 8'h8F;

   ////////////////////////////////////////////////////////////////////////////////////
   // Source select codes
   localparam int         NSRC          = 8;
   localparam logic [3:0] SEL_GND       = 4'h0;
   localparam logic [3:0] SEL_PWM_BASE  = 4'h4;
   localparam logic [3:0] SEL_RSVD      = 4'h8;
   localparam logic [3:0] MSRC_SW       = 4'h0;
   localparam logic [3:0] MSRC_PIN      = 4'h1;
   localparam logic [3:0] MSRC_PWM_BASE = 4'h2;

   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

endpackage

// *** hw/carrier_sel_if.sv ***
`timescale 1ns/10ps
interface carrier_sel_if;
   logic [3:0] sel;
   logic       invert;
   logic [7:0] sources;
   logic       result;

   modport user (output sel, output invert, output sources, input result);
   modport mux  (input sel, input invert, input sources, output result);
endinterface

// *** hw/carrier_mux.sv ***
`timescale 1ns/10ps
module carrier_mux (
   carrier_sel_if.mux bus
);

   // Reserved codes feed a constant low, then the polarity stage
   always_comb begin
      if (bus.sel < dsm_pkg::SEL_RSVD) begin
         bus.result = bus.sources[bus.sel[2:0]] ^ bus.invert;
      end else begin
         bus.result = bus.invert;
      end
   end

endmodule

// *** hw/signal_modulator.sv ***
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module signal_modulator (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        carrier_input_pin_one,
   input  wire logic        carrier_input_pin_two,
   input  wire logic        ref_clock_signal,
   input  wire logic        modulation_input_pin,
   input  wire logic [3:0]  pwm_output,
   input  wire logic [3:0]  pwm_mode_active,
   output logic             modulated_output,
   output logic             modulated_output_oe,
   output logic             slew_limit_control,
   output logic [3:0]       pwm_pin_release
);

   ////////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] src;
      logic [7:0] carh;
      logic [7:0] carl;
      logic       aw_ready;
      logic       w_ready;
      logic       aw_have;
      logic       w_have;
      logic [7:0] aw_addr;
      logic [7:0] w_data;
      logic       w_lane0;
      logic       b_valid;
      logic [1:0] b_resp;
      logic       ar_ready;
      logic       r_valid;
      logic [1:0] r_resp;
      logic [7:0] r_data;
      logic       sel_high;
      logic       prev_high;
      logic       prev_low;
      logic       out;
      logic       oe;
      logic       slr;
      logic [3:0] release_pins;
   } state_s;

   localparam state_s ST_RST = '{
      ctl:      dsm_pkg::CTL_RST,
      src:      dsm_pkg::SRC_RST,
      carh:     dsm_pkg::CAR_RST,
      carl:     dsm_pkg::CAR_RST,
      aw_ready: 1'b1,
      w_ready:  1'b1,
      ar_ready: 1'b1,
      slr:      dsm_pkg::CTL_RST[dsm_pkg::CTL_SLR],
      default:  '0
   };

   state_s     st_r;
   state_s     st_nxt;
   logic       en_c;
   logic       hi_c;
   logic       lo_c;
   logic       mod_c;
   logic       use_high_c;
   logic       mix_c;
   logic       wr_fire_c;
   logic [3:0] rel_c;
   logic [3:0] pwm_src_c;

   ////////////////////////////////////////////////////////////////////////////////////
   // Source selection: 0 high carrier, 1 low carrier, 2 modulation

   carrier_sel_if cif [3] ();

   logic [3:0] sel_v [3];
   logic       inv_v [3];
   logic [7:0] src_v [3];
   logic       res_v [3];

   // PWM outputs only count as sources while in PWM mode
   assign pwm_src_c = pwm_output & pwm_mode_active;

   assign sel_v[0] = st_r.carh[3:0];
   assign sel_v[1] = st_r.carl[3:0];
   assign sel_v[2] = st_r.src[3:0];
   assign inv_v[0] = st_r.carh[dsm_pkg::CAR_POL];
   assign inv_v[1] = st_r.carl[dsm_pkg::CAR_POL];
   assign inv_v[2] = 1'b0;
   assign src_v[0] = {pwm_src_c, ref_clock_signal, carrier_input_pin_two,
                      carrier_input_pin_one, 1'b0};
   assign src_v[1] = src_v[0];
   assign src_v[2] = {2'b00, pwm_src_c, modulation_input_pin,
                      st_r.ctl[dsm_pkg::CTL_BIT]};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sel
         assign cif[gi].sel     = sel_v[gi];
         assign cif[gi].invert  = inv_v[gi];
         assign cif[gi].sources = src_v[gi];
         assign res_v[gi]       = cif[gi].result;
         carrier_mux u_mux (
            .bus (cif[gi])
         );
      end
   endgenerate

   assign hi_c  = res_v[0];
   assign lo_c  = res_v[1];
   assign mod_c = res_v[2];
   assign en_c  = st_r.ctl[dsm_pkg::CTL_EN];

   ////////////////////////////////////////////////////////////////////////////////////
   // Pin release towards the PWM units

   genvar gk;
   generate
      for (gk = 0; gk < 4; gk++) begin : g_rel
         assign rel_c[gk] = en_c & (
            (st_r.carh[3:0] == 4'(dsm_pkg::SEL_PWM_BASE + gk)
               && st_r.carh[dsm_pkg::CAR_DIS]) |
            (st_r.carl[3:0] == 4'(dsm_pkg::SEL_PWM_BASE + gk)
               && st_r.carl[dsm_pkg::CAR_DIS]) |
            (st_r.src[3:0] == 4'(dsm_pkg::MSRC_PWM_BASE + gk)
               && st_r.src[dsm_pkg::SRC_DIS]));
      end
   endgenerate

   assign wr_fire_c = st_r.aw_have & st_r.w_have & ~st_r.b_valid;

   ////////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      st_nxt = st_r;

      // Write channels are taken independently; the response waits for both
      if (awvalid && st_r.aw_ready) begin
         st_nxt.aw_ready = 1'b0;
         st_nxt.aw_have  = 1'b1;
         st_nxt.aw_addr  = awaddr;
      end
      if (wvalid && st_r.w_ready) begin
         st_nxt.w_ready = 1'b0;
         st_nxt.w_have  = 1'b1;
         st_nxt.w_data  = wdata[7:0];
         st_nxt.w_lane0 = wstrb[0];
      end
      if (wr_fire_c) begin
         st_nxt.b_valid = 1'b1;
         st_nxt.b_resp  = dsm_pkg::RESP_OKAY;
         case (st_r.aw_addr)
            dsm_pkg::CTL_ADDR: begin
               if (st_r.w_lane0) begin
                  st_nxt.ctl = (st_r.ctl & ~dsm_pkg::CTL_WMASK)
                             | (st_r.w_data & dsm_pkg::CTL_WMASK);
               end
            end
            dsm_pkg::SRC_ADDR: begin
               if (st_r.w_lane0) begin
                  st_nxt.src = (st_r.src & ~dsm_pkg::SRC_WMASK)
                             | (st_r.w_data & dsm_pkg::SRC_WMASK);
               end
            end
            dsm_pkg::CARH_ADDR: begin
               if (st_r.w_lane0) begin
                  st_nxt.carh = (st_r.carh & ~dsm_pkg::CAR_WMASK)
                              | (st_r.w_data & dsm_pkg::CAR_WMASK);
               end
            end
            dsm_pkg::CARL_ADDR: begin
               if (st_r.w_lane0) begin
                  st_nxt.carl = (st_r.carl & ~dsm_pkg::CAR_WMASK)
                              | (st_r.w_data & dsm_pkg::CAR_WMASK);
               end
            end
            default: begin
               st_nxt.b_resp = dsm_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (st_r.b_valid && bready) begin
         st_nxt.b_valid  = 1'b0;
         st_nxt.aw_have  = 1'b0;
         st_nxt.w_have   = 1'b0;
         st_nxt.aw_ready = 1'b1;
         st_nxt.w_ready  = 1'b1;
      end

      // Read: one outstanding, answered the cycle after the address is taken
      if (arvalid && st_r.ar_ready) begin
         st_nxt.ar_ready = 1'b0;
         st_nxt.r_valid  = 1'b1;
         st_nxt.r_resp   = dsm_pkg::RESP_OKAY;
         case (araddr)
            dsm_pkg::CTL_ADDR: begin
               st_nxt.r_data = st_r.ctl;
               st_nxt.r_data[dsm_pkg::CTL_OUT] = st_r.out;
            end
            dsm_pkg::SRC_ADDR: begin
               st_nxt.r_data = st_r.src;
            end
            dsm_pkg::CARH_ADDR: begin
               st_nxt.r_data = st_r.carh;
            end
            dsm_pkg::CARL_ADDR: begin
               st_nxt.r_data = st_r.carl;
            end
            default: begin
               st_nxt.r_data = 8'h00;
               st_nxt.r_resp = dsm_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (st_r.r_valid && rready) begin
         st_nxt.r_valid  = 1'b0;
         st_nxt.ar_ready = 1'b1;
      end

      // Carrier switch; without sync the switch is immediate and may clip a pulse
      use_high_c = st_r.sel_high;
      if (!en_c) begin
         use_high_c = 1'b0;
      end else if (mod_c && !st_r.sel_high) begin
         if (!st_r.carl[dsm_pkg::CAR_SYNC] || (st_r.prev_low && !lo_c)) begin
            use_high_c = 1'b1;
         end
      end else if (!mod_c && st_r.sel_high) begin
         if (!st_r.carh[dsm_pkg::CAR_SYNC] || (st_r.prev_high && !hi_c)) begin
            use_high_c = 1'b0;
         end
      end
      mix_c = use_high_c ? hi_c : lo_c;

      st_nxt.sel_high     = use_high_c;
      st_nxt.prev_high    = hi_c;
      st_nxt.prev_low     = lo_c;
      st_nxt.out          = en_c & (mix_c ^ st_r.ctl[dsm_pkg::CTL_OPOL]);
      st_nxt.oe           = en_c & st_r.ctl[dsm_pkg::CTL_OE];
      st_nxt.slr          = st_r.ctl[dsm_pkg::CTL_SLR];
      st_nxt.release_pins = rel_c;
   end

   // No clock gating: a sleeping core leaves this logic running
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign awready             = st_r.aw_ready;
   assign wready              = st_r.w_ready;
   assign bvalid              = st_r.b_valid;
   assign bresp               = st_r.b_resp;
   assign arready             = st_r.ar_ready;
   assign rvalid              = st_r.r_valid;
   assign rresp               = st_r.r_resp;
   assign rdata               = {24'h00_0000, st_r.r_data};
   assign modulated_output    = st_r.out;
   assign modulated_output_oe = st_r.oe;
   assign slew_limit_control  = st_r.slr;
   assign pwm_pin_release     = st_r.release_pins;

   ////////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   hi_invert_a: assert property (
      (st_r.carh[3:0] == dsm_pkg::SEL_GND) |-> hi_c == st_r.carh[dsm_pkg::CAR_POL])
      else $error("high carrier polarity wrong");

   lo_invert_a: assert property (
      (st_r.carl[3:0] == 4'h1) |-> lo_c == (carrier_input_pin_one
                                            ^ st_r.carl[dsm_pkg::CAR_POL]))
      else $error("low carrier polarity wrong");

   pin_release_a: assert property (
      en_c && st_r.carh[3:0] == dsm_pkg::SEL_PWM_BASE && st_r.carh[dsm_pkg::CAR_DIS]
      |=> pwm_pin_release[0])
      else $error("carrier pin not released");

   sw_bit_a: assert property (
      (st_r.src[3:0] == dsm_pkg::MSRC_SW) |-> mod_c == st_r.ctl[dsm_pkg::CTL_BIT])
      else $error("software modulation bit not selected");

   mod_release_a: assert property (
      en_c && st_r.src[3:0] == dsm_pkg::MSRC_PWM_BASE && st_r.src[dsm_pkg::SRC_DIS]
      |=> pwm_pin_release[0])
      else $error("modulation pin not released");

   out_polarity_a: assert property (
      en_c |=> modulated_output == ($past(mix_c) ^ $past(st_r.ctl[dsm_pkg::CTL_OPOL])))
      else $error("output polarity wrong");

   slew_follow_a: assert property (
      ##1 slew_limit_control == $past(st_r.ctl[dsm_pkg::CTL_SLR]))
      else $error("slew control does not follow register");

   reset_state_a: assert property (
      @(posedge aclk) disable iff (1'b0)
      !aresetn |=> st_r.ctl == dsm_pkg::CTL_RST && !modulated_output && !modulated_output_oe)
      else $error("reset did not disable modulator");

   sync_wait_a: assert property (
      $rose(st_r.sel_high) && $past(st_r.carl[dsm_pkg::CAR_SYNC])
      |-> $past(st_r.prev_low && !lo_c))
      else $error("switch to high without low carrier falling edge");

   nosync_switch_a: assert property (
      en_c && mod_c && !st_r.sel_high && !st_r.carl[dsm_pkg::CAR_SYNC] |=> st_r.sel_high)
      else $error("unsynchronised switch delayed");

   high_path_a: assert property (
      st_r.sel_high && en_c && !st_r.ctl[dsm_pkg::CTL_OPOL] |=> modulated_output == $past(hi_c)
      || !$past(mod_c))
      else $error("high carrier not routed");

   disabled_out_a: assert property (
      !en_c |=> !modulated_output && !modulated_output_oe)
      else $error("output active while disabled");

   cov_write: cover property (st_r.b_valid && bready);
   cov_read: cover property (st_r.r_valid && rready);
   cov_sync_switch: cover property ($rose(st_r.sel_high) && st_r.carl[dsm_pkg::CAR_SYNC]);
   cov_output_high: cover property (modulated_output && modulated_output_oe);

endmodule

// *** verification/source_model.sv ***
`timescale 1ns/10ps
module source_model (
   input  wire logic        aclk,
   input  wire logic        run,
   input  wire logic [11:0] level,
   output logic             pin_one,
   output logic             pin_two,
   output logic             ref_clk,
   output logic             mod_pin,
   output logic [3:0]       pwm,
   output logic [3:0]       pwm_mode
);
   logic [7:0] cnt_r = 8'h00;

   always_ff @(posedge aclk) begin
      cnt_r <= cnt_r + 8'h01;
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // Free running sources stand for peripherals that keep clocking in sleep
   always_comb begin
      if (run) begin
         {pwm, mod_pin, ref_clk, pin_two, pin_one} = {cnt_r[7:1] ^ cnt_r[6:0], cnt_r[0]};
      end else begin
         {pwm, mod_pin, ref_clk, pin_two, pin_one} = level[7:0];
      end
      pwm_mode = level[11:8];
   end
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, run, mout, moe, slew, prev;
   logic        p1, p2, rc, mp;
   logic [7:0]  awaddr, araddr;
   logic        exp_bit;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb, pwm, pmode, rel;
   logic [1:0]  bresp, rresp;
   logic [11:0] lv;
   logic [11:0] pats [3] = '{12'h05FF, 12'h0AFF, 12'h0F5A};
   int          num_errors, comparisons;

   source_model src (.aclk(aclk), .run(run), .level(lv), .pin_one(p1), .pin_two(p2),
                     .ref_clk(rc), .mod_pin(mp), .pwm(pwm), .pwm_mode(pmode));

   signal_modulator uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .carrier_input_pin_one(p1), .carrier_input_pin_two(p2),
      .ref_clock_signal(rc), .modulation_input_pin(mp), .pwm_output(pwm),
      .pwm_mode_active(pmode), .modulated_output(mout), .modulated_output_oe(moe),
      .slew_limit_control(slew), .pwm_pin_release(rel));

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      if (num_errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask

   task automatic chk_pin(input string nm, input logic e, input logic g);
      chk(nm, {31'h0, e}, {31'h0, g});
   endtask

   task automatic hang(input string nm);
      num_errors++;
      $display("unexpected %s: expected answer, seen none", nm);
      test_done();
   endtask

   ////////////////////////////////////////////////////////////////////////////////////
   // Bus cycles; each starts one edge after the last so no signal is set twice at once
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      int n;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= {24'h00_0000, d};
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (n == 40) hang("bvalid");
      bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      int n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (n == 40) hang("rvalid");
      rready <= 1'b0;
      chk("rdata", {24'h00_0000, e}, rdata);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
   endtask

   task automatic set(input logic [7:0] a, input logic [7:0] d);
      wr(a, d, 4'hF, dsm_pkg::RESP_OKAY);
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge aclk);
      #1;
   endtask

   task automatic setlv(input logic [11:0] v);
      @(posedge aclk);
      lv <= v;
   endtask

   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(dsm_pkg::CTL_ADDR, dsm_pkg::CTL_RST, dsm_pkg::RESP_OKAY);
      rchk(dsm_pkg::SRC_ADDR, dsm_pkg::SRC_RST, dsm_pkg::RESP_OKAY);
      rchk(dsm_pkg::CARH_ADDR, dsm_pkg::CAR_RST, dsm_pkg::RESP_OKAY);
      rchk(dsm_pkg::CARL_ADDR, dsm_pkg::CAR_RST, dsm_pkg::RESP_OKAY);
      tick(1);
      chk_pin("oe", 1'b0, moe);
      chk_pin("out", 1'b0, mout);
      chk_pin("slew", 1'b1, slew);
      chk("release", 32'h0, {28'h0, rel});
   endtask

   function automatic logic car_src(input logic [3:0] c, input logic [11:0] v);
      if (c == 4'h0 || c >= 4'h8) return 1'b0;
      if (c <= 4'h3) return v[c - 4'h1];
      return v[4 + c[1:0]] & v[8 + c[1:0]];
   endfunction

   function automatic logic mod_src(input logic [3:0] c, input logic s, input logic [11:0] v);
      logic [3:0] k;
      k = c - 4'h2;
      if (c == 4'h0) return s;
      if (c == 4'h1) return v[3];
      if (c <= 4'h5) return v[4 + k[1:0]] & v[8 + k[1:0]];
      return 1'b0;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, run} = 6'h00;
      awaddr      = 8'h00;
      araddr      = 8'h00;
      wdata       = 32'h0000_0000;
      wstrb       = 4'h0;
      lv          = 12'h000;
      num_errors  = 0;
      comparisons = 0;
      do_reset();
      wr(dsm_pkg::CTL_ADDR, 8'h7F, 4'hF, dsm_pkg::RESP_OKAY);
      wr(dsm_pkg::CTL_ADDR, 8'h00, 4'hE, dsm_pkg::RESP_OKAY);
      rchk(dsm_pkg::CTL_ADDR, 8'h7F & dsm_pkg::CTL_WMASK, dsm_pkg::RESP_OKAY);
      set(dsm_pkg::SRC_ADDR, 8'hFF);
      rchk(dsm_pkg::SRC_ADDR, 8'hFF & dsm_pkg::SRC_WMASK, dsm_pkg::RESP_OKAY);
      set(dsm_pkg::CARH_ADDR, 8'hFF);
      rchk(dsm_pkg::CARH_ADDR, 8'hFF & dsm_pkg::CAR_WMASK, dsm_pkg::RESP_OKAY);
      set(dsm_pkg::CARL_ADDR, 8'hFF);
      rchk(dsm_pkg::CARL_ADDR, 8'hFF & dsm_pkg::CAR_WMASK, dsm_pkg::RESP_OKAY);
      wr(8'h10, 8'hFF, 4'hF, dsm_pkg::RESP_SLVERR);
      rchk(8'h10, 8'h00, dsm_pkg::RESP_SLVERR);
      @(posedge aclk);
      do_reset();
      // Every carrier code on both carriers, with carrier and output inversion
      for (int p = 0; p < 3; p++) begin
         setlv(pats[p]);
         for (int h = 0; h < 2; h++) begin
            set(dsm_pkg::CARH_ADDR, 8'h00);
            set(dsm_pkg::CARL_ADDR, 8'h00);
            set(dsm_pkg::CTL_ADDR, {3'b111, p[0], 3'b000, ~h[0]});
            for (int c = 0; c < 16; c++) begin
               for (int v = 0; v < 2; v++) begin
                  set(h[0] ? dsm_pkg::CARL_ADDR : dsm_pkg::CARH_ADDR,
                      {1'b0, v[0], 2'b00, c[3:0]});
                  tick(2);
                  exp_bit = car_src(c[3:0], pats[p]) ^ v[0] ^ p[0];
                  chk_pin("out", exp_bit, mout);
               end
            end
         end
      end
      // Every modulation source code, carriers fixed at one and zero
      set(dsm_pkg::CARH_ADDR, 8'h40);
      set(dsm_pkg::CARL_ADDR, 8'h00);
      for (int p = 0; p < 3; p++) begin
         setlv(pats[p]);
         for (int s = 0; s < 2; s++) begin
            set(dsm_pkg::CTL_ADDR, {7'h60, s[0]});
            for (int c = 0; c < 16; c++) begin
               set(dsm_pkg::SRC_ADDR, {4'h0, c[3:0]});
               tick(2);
               chk_pin("out", mod_src(c[3:0], s[0], pats[p]), mout);
            end
         end
      end
      // Pin release of a selected capture/compare unit
      set(dsm_pkg::CTL_ADDR, 8'hC0);
      for (int k = 0; k < 4; k++) begin
         for (int r = 0; r < 3; r++) begin
            set(dsm_pkg::CARH_ADDR, r == 0 ? {4'h8, 4'(4 + k)} : 8'h00);
            set(dsm_pkg::CARL_ADDR, r == 1 ? {4'h8, 4'(4 + k)} : 8'h00);
            set(dsm_pkg::SRC_ADDR, r == 2 ? {4'h8, 4'(2 + k)} : 8'h00);
            tick(2);
            chk("release", 32'h1 << k, {28'h0, rel});
         end
      end
      set(dsm_pkg::CTL_ADDR, 8'h41);
      tick(2);
      chk("release", 32'h0, {28'h0, rel});
      chk_pin("oe", 1'b0, moe);
      // Enables, slew and output state bit
      set(dsm_pkg::CARH_ADDR, 8'h40);
      set(dsm_pkg::SRC_ADDR, 8'h00);
      tick(2);
      chk_pin("out", 1'b0, mout);
      set(dsm_pkg::CTL_ADDR, 8'hC1);
      tick(2);
      chk_pin("oe", 1'b1, moe);
      chk_pin("slew", 1'b0, slew);
      rchk(dsm_pkg::CTL_ADDR, 8'hC9, dsm_pkg::RESP_OKAY);
      set(dsm_pkg::CTL_ADDR, 8'hA1);
      tick(2);
      chk_pin("oe", 1'b0, moe);
      chk_pin("slew", 1'b1, slew);
      // Low carrier synchronisation holds the switch until its falling edge
      set(dsm_pkg::CARH_ADDR, 8'h02);
      set(dsm_pkg::CARL_ADDR, 8'h21);
      set(dsm_pkg::SRC_ADDR, 8'h01);
      set(dsm_pkg::CTL_ADDR, 8'hC0);
      setlv(12'h001);
      tick(2);
      chk_pin("out", 1'b1, mout);
      setlv(12'h009);
      tick(3);
      chk_pin("out", 1'b1, mout);
      setlv(12'h008);
      tick(2);
      setlv(12'h009);
      tick(2);
      chk_pin("out", 1'b0, mout);
      set(dsm_pkg::CARL_ADDR, 8'h01);
      setlv(12'h001);
      tick(2);
      setlv(12'h009);
      tick(2);
      chk_pin("out", 1'b0, mout);
      // Free running sources, as in sleep, are followed one cycle later
      set(dsm_pkg::CARH_ADDR, 8'h01);
      set(dsm_pkg::SRC_ADDR, 8'h00);
      set(dsm_pkg::CTL_ADDR, 8'hC1);
      @(posedge aclk);
      run <= 1'b1;
      tick(2);
      prev = p1;
      repeat (20) begin
         tick(1);
         chk_pin("out", prev, mout);
         prev = p1;
      end
      @(posedge aclk);
      run <= 1'b0;
      do_reset();
      test_done();
   end
endmodule
